// File: cirq_regs.sv
// clock source event register and high-speed bus peripheral reset registers
// assumes an apb master on i_ref_clk and oscillator ready levels synchronous to it
//
// Register access over APB was decided locally.
`default_nettype none
// Function
// - stuck crystal sets flag 7, clear bit 23
// - digital pll flag 6 set when enabled 14
// - audio pll flag 5 set when enabled 13
// - main pll flag 4 set when enabled 12
// - fast crystal flag 3 set when enabled 11
// - rc16 flag 2 set when enabled 10
// - slow crystal flag 1 set when enabled 9
// - rc32k flag 0 set when enabled 8
// - write one to bits 22..16 clears flags
// - enables read-write, flags read-only
// - event register at 0x0C, resets zero
// - gpio ports c, b, a resets
// - bus two reset register byte lane writes
// - reset bits software only, reset zero
// - stuck detection only with monitor enabled
module cirq_regs #(
  parameter int STUCK_CYCLES = cirq_pkg::CIRQ_STUCK_CYCLES
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // oscillator and pll ready levels, bit order rc32k..digital pll
  input  wire logic [6:0]  i_src_stable,
  // fast crystal clock sampled as a level
  input  wire logic        i_high_speed_crystal,
  // interrupt request
  output logic             o_clock_irq,
  // usb, dma, wireless, checksum, touch, security gate and gpio resets
  output logic             o_usb_ctrl_reset,
  output logic             o_dma_second_reset,
  output logic             o_dma_first_reset,
  output logic             o_wireless_reset,
  output logic             o_checksum_reset,
  output logic             o_touch_sense_reset,
  output logic             o_security_gate_reset,
  output logic             o_port_c_reset,
  output logic             o_port_b_reset,
  output logic             o_port_a_reset,
  // crypto and camera resets
  output logic             o_random_gen_reset,
  output logic             o_hash_unit_reset,
  output logic             o_cipher_unit_reset,
  output logic             o_public_key_unit_reset,
  output logic             o_camera_if_reset,
  // memory interface resets
  output logic             o_quad_flash_if_reset,
  output logic             o_psram_if_reset
);
  import cirq_pkg::*;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  cirq_state_t state_reg;
  logic        access;
  logic        setup_seen;
  logic        wr_en;
  logic        hit;
  logic [31:0] strb_mask;
  logic        sel_event;
  logic        sel_bus1;
  logic        sel_bus2;
  logic        sel_bus3;
  logic        sel_monitor;
  logic        wr_event;
  logic        wr_bus1;
  logic        wr_bus2;
  logic        wr_bus3;
  logic        wr_monitor;

  // no wait states: ready during every access phase
  assign access     = i_psel && i_penable;
  assign o_pready   = access;
  // an access phase with no setup cycle before it is answered but writes nothing
  assign setup_seen = (state_reg == CIRQ_ST_ACCESS);
  assign wr_en      = access && setup_seen && i_pwrite && !o_pslverr;
  assign strb_mask  = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  // one address decode per register, shared by the write enables and the error answer
  assign sel_event   = (i_paddr == CIRQ_OFS_CLOCK_EVENT_IRQ);
  assign sel_bus1    = (i_paddr == CIRQ_OFS_HSBUS1_RESET);
  assign sel_bus2    = (i_paddr == CIRQ_OFS_HSBUS2_RESET);
  assign sel_bus3    = (i_paddr == CIRQ_OFS_HSBUS3_RESET);
  assign sel_monitor = (i_paddr == CIRQ_OFS_MONITOR_CTRL);
  assign hit         = sel_event || sel_bus1 || sel_bus2 || sel_bus3 || sel_monitor;
  assign wr_event    = wr_en && sel_event;
  assign wr_bus1     = wr_en && sel_bus1;
  assign wr_bus2     = wr_en && sel_bus2;
  assign wr_bus3     = wr_en && sel_bus3;
  assign wr_monitor  = wr_en && sel_monitor;
  // unmapped addresses answer with an error and have no effect
  assign o_pslverr = access && !hit;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      state_reg <= CIRQ_ST_IDLE;
    else
    begin
      case (state_reg)
        CIRQ_ST_IDLE:   if (i_psel && !i_penable) state_reg <= CIRQ_ST_ACCESS;
        CIRQ_ST_ACCESS: if (access) state_reg <= CIRQ_ST_IDLE;
        default:        state_reg <= CIRQ_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  logic [6:0]  irq_en_reg;
  logic        monitor_en_reg;
  logic [31:0] hsbus1_reg;
  logic [31:0] hsbus2_reg;
  logic [31:0] hsbus3_reg;
  logic [31:0] wdata_m;

  // byte lanes that are not strobed keep their old content
  function automatic logic [31:0] cirq_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [31:0] lanes, input logic [31:0] keep);
    cirq_merge = ((old_v & ~lanes) | (new_v & lanes)) & keep;
  endfunction : cirq_merge

  assign wdata_m = i_pwdata & strb_mask;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      irq_en_reg <= CIRQ_EN_RESET;
    else if (wr_event && i_pstrb[1])
      irq_en_reg <= i_pwdata[CIRQ_EN_LSB +: CIRQ_NUM_SRC];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      monitor_en_reg <= 1'b0;
    else if (wr_monitor && i_pstrb[0])
      monitor_en_reg <= i_pwdata[0];
  end

  // reserved positions are masked, so they stay zero whatever is written
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      hsbus1_reg <= CIRQ_RESET_VAL;
    else if (wr_bus1)
      hsbus1_reg <= cirq_merge(hsbus1_reg, i_pwdata, strb_mask, CIRQ_HSBUS1_MASK);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      hsbus2_reg <= CIRQ_RESET_VAL;
    else if (wr_bus2)
      hsbus2_reg <= cirq_merge(hsbus2_reg, i_pwdata, strb_mask, CIRQ_HSBUS2_MASK);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      hsbus3_reg <= CIRQ_RESET_VAL;
    else if (wr_bus3)
      hsbus3_reg <= cirq_merge(hsbus3_reg, i_pwdata, strb_mask, CIRQ_HSBUS3_MASK);
  end

  // ----------------------------------------------------------------
  // stabilization events
  // ----------------------------------------------------------------
  logic [6:0] stable_d_reg;
  logic [6:0] stable_rise;
  logic [6:0] clr_bits;
  logic [6:0] src_flags;
  logic       clr_wr;

  // a flag fires on the ready edge, not on the level, so a cleared flag stays clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      stable_d_reg <= 7'h00;
    else
      stable_d_reg <= i_src_stable;
  end

  assign stable_rise = i_src_stable & ~stable_d_reg;
  assign clr_wr      = wr_event && i_pstrb[2];
  assign clr_bits    = clr_wr ? wdata_m[CIRQ_CLR_LSB +: CIRQ_NUM_SRC] : 7'h00;

  // bit 6 digital pll, 5 audio pll, 4 main pll, 3 fast crystal,
  // 2 rc16, 1 slow crystal, 0 rc32k
  genvar gi;
  generate
    for (gi = 0; gi < CIRQ_NUM_SRC; gi++)
    begin : g_src
      cirq_flag_cell u_flag (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_event   (stable_rise[gi]),
        .i_enable  (irq_en_reg[gi]),
        .i_clear   (clr_bits[gi]),
        .o_flag    (src_flags[gi])
      );
    end
  endgenerate

  // named views of the source flags, highest register bit first
  logic digital_pll_stable_flag;
  logic audio_pll_stable_flag;
  logic main_pll_stable_flag;
  logic fast_crystal_stable_flag;
  logic rc16_stable_flag;
  logic slow_crystal_stable_flag;
  logic rc32k_stable_flag;
  assign digital_pll_stable_flag  = src_flags[6];
  assign audio_pll_stable_flag    = src_flags[5];
  assign main_pll_stable_flag     = src_flags[4];
  assign fast_crystal_stable_flag = src_flags[3];
  assign rc16_stable_flag         = src_flags[2];
  assign slow_crystal_stable_flag = src_flags[1];
  assign rc32k_stable_flag        = src_flags[0];

  // ----------------------------------------------------------------
  // crystal stuck monitor
  // ----------------------------------------------------------------
  logic        xtal_d_reg;
  logic [15:0] quiet_cnt_reg;
  logic        stuck_event;
  logic        stuck_flag;
  logic        stuck_clr;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      xtal_d_reg <= 1'b0;
    else
      xtal_d_reg <= i_high_speed_crystal;
  end

  // limitation: the crystal is sampled by i_ref_clk, so a crystal near that rate or a multiple of it
  // can alias to a steady level; the stuck time must span many crystal periods
  // a crystal held low or high stops producing edges; counting saturates
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      quiet_cnt_reg <= 16'h0000;
    else if (!monitor_en_reg || (xtal_d_reg != i_high_speed_crystal))
      quiet_cnt_reg <= 16'h0000;
    else if (quiet_cnt_reg != 16'(STUCK_CYCLES))
      quiet_cnt_reg <= quiet_cnt_reg + 16'h0001;
  end

  assign stuck_event = monitor_en_reg && (quiet_cnt_reg == 16'(STUCK_CYCLES));
  assign stuck_clr   = clr_wr && wdata_m[CIRQ_STUCK_CLR];

  cirq_flag_cell u_stuck (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_event   (stuck_event),
    .i_enable  (1'b1),
    .i_clear   (stuck_clr),
    .o_flag    (stuck_flag)
  );

  assign o_clock_irq = stuck_flag || (|src_flags);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rdata;

  // clear bits are write-only and read as zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      CIRQ_OFS_CLOCK_EVENT_IRQ:
      begin
        rdata[CIRQ_FLAG_LSB +: CIRQ_NUM_SRC] = {digital_pll_stable_flag, audio_pll_stable_flag,
                                                main_pll_stable_flag, fast_crystal_stable_flag,
                                                rc16_stable_flag, slow_crystal_stable_flag,
                                                rc32k_stable_flag};
        rdata[CIRQ_STUCK_FLAG]               = stuck_flag;
        rdata[CIRQ_EN_LSB +: CIRQ_NUM_SRC]   = irq_en_reg;
      end
      CIRQ_OFS_HSBUS1_RESET: rdata = hsbus1_reg;
      CIRQ_OFS_HSBUS2_RESET: rdata = hsbus2_reg;
      CIRQ_OFS_HSBUS3_RESET: rdata = hsbus3_reg;
      CIRQ_OFS_MONITOR_CTRL: rdata[0] = monitor_en_reg;
      default:               rdata = 32'h0000_0000;
    endcase
  end

  // read data is registered in the setup cycle, valid in the access phase
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= rdata;
  end

  // ----------------------------------------------------------------
  // reset outputs, straight from the registers
  // ----------------------------------------------------------------
  assign o_usb_ctrl_reset        = hsbus1_reg[29];
  assign o_dma_second_reset      = hsbus1_reg[22];
  assign o_dma_first_reset       = hsbus1_reg[21];
  assign o_wireless_reset        = hsbus1_reg[13];
  assign o_checksum_reset        = hsbus1_reg[12];
  assign o_touch_sense_reset     = hsbus1_reg[8];
  assign o_security_gate_reset   = hsbus1_reg[7];
  assign o_port_c_reset          = hsbus1_reg[2];
  assign o_port_b_reset          = hsbus1_reg[1];
  assign o_port_a_reset          = hsbus1_reg[0];
  assign o_random_gen_reset      = hsbus2_reg[6];
  assign o_hash_unit_reset       = hsbus2_reg[5];
  assign o_cipher_unit_reset     = hsbus2_reg[4];
  assign o_public_key_unit_reset = hsbus2_reg[3];
  assign o_camera_if_reset       = hsbus2_reg[0];
  assign o_quad_flash_if_reset   = hsbus3_reg[1];
  assign o_psram_if_reset        = hsbus3_reg[0];
endmodule : cirq_regs
`default_nettype wire

// File: cirq_pkg.sv
// package for the clock event and peripheral reset register bank
// assumes a 32-bit apb slave with word aligned registers
`default_nettype none
package cirq_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CIRQ_OFS_CLOCK_EVENT_IRQ = 8'h0C;
  localparam logic [7:0] CIRQ_OFS_HSBUS1_RESET    = 8'h10;
  localparam logic [7:0] CIRQ_OFS_HSBUS2_RESET    = 8'h14;
  localparam logic [7:0] CIRQ_OFS_HSBUS3_RESET    = 8'h18;
  localparam logic [7:0] CIRQ_OFS_MONITOR_CTRL    = 8'h1C;
  // ----------------------------------------------------------------
  // field positions of the clock event register
  // ----------------------------------------------------------------
  localparam int CIRQ_NUM_SRC       = 7;
  localparam int CIRQ_FLAG_LSB      = 0;
  localparam int CIRQ_STUCK_FLAG    = 7;
  localparam int CIRQ_EN_LSB        = 8;
  localparam int CIRQ_CLR_LSB       = 16;
  localparam int CIRQ_STUCK_CLR     = 23;
  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CIRQ_HSBUS1_MASK = 32'h2060_3187;
  localparam logic [31:0] CIRQ_HSBUS2_MASK = 32'h0000_0079;
  localparam logic [31:0] CIRQ_HSBUS3_MASK = 32'h0000_0003;
  localparam logic [31:0] CIRQ_RESET_VAL   = 32'h0000_0000;
  localparam logic [6:0]  CIRQ_EN_RESET    = 7'h00;
  // ----------------------------------------------------------------
  // crystal monitor timing
  // ----------------------------------------------------------------
  localparam int CIRQ_CLK_MHZ          = 100;
  localparam int CIRQ_STUCK_TIME_NS    = 1000;
  localparam int CIRQ_STUCK_CYCLES     = (CIRQ_STUCK_TIME_NS * CIRQ_CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // apb access states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CIRQ_ST_IDLE   = 2'b01,
    CIRQ_ST_ACCESS = 2'b10
  } cirq_state_t;
endpackage : cirq_pkg
`default_nettype wire

// File: cirq_flag_cell.sv
// one sticky event flag with enable gating and write-one clear
// assumes the event input is synchronous to i_ref_clk: a single-cycle rising-edge pulse, or a level held while the crystal stays stuck
`default_nettype none
module cirq_flag_cell (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  // control
  input  wire logic i_event,
  input  wire logic i_enable,
  input  wire logic i_clear,
  // status
  output logic      o_flag
);
  import cirq_pkg::*;

  logic flag_reg;

  // set beats clear so an event in the clear cycle is kept
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      flag_reg <= 1'b0;
    else if (i_event && i_enable)
      flag_reg <= 1'b1;
    else if (i_clear)
      flag_reg <= 1'b0;
  end

  assign o_flag = flag_reg;
endmodule : cirq_flag_cell
`default_nettype wire

// File: cirq_regs_chk.sv
// checker for the clock event and peripheral reset register bank
// assumes it is bound to cirq_regs and sees only that module's ports
`default_nettype none
module cirq_regs_chk (
  // clock, reset and apb
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  // watched outputs
  input  wire logic        o_clock_irq,
  input  wire logic        o_usb_ctrl_reset,
  input  wire logic        o_port_a_reset,
  input  wire logic        o_random_gen_reset,
  input  wire logic        o_psram_if_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import cirq_pkg::*;
  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  wire acc    = i_psel && i_penable;
  wire wr     = acc && i_pwrite;
  wire mapped = i_paddr inside {CIRQ_OFS_CLOCK_EVENT_IRQ, CIRQ_OFS_HSBUS1_RESET,
                CIRQ_OFS_HSBUS2_RESET, CIRQ_OFS_HSBUS3_RESET, CIRQ_OFS_MONITOR_CTRL};
  wire wr1    = wr && i_paddr == CIRQ_OFS_HSBUS1_RESET;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ready_no_wait: assert property (acc |-> o_pready)
    else $error("pready low in access phase");
  a_err_unmapped: assert property (acc && !mapped |-> o_pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && mapped |-> !o_pslverr)
    else $error("error on mapped access");
  a_irq_clear_write: assert property ($fell(o_clock_irq) |->
    $past(wr && i_paddr == CIRQ_OFS_CLOCK_EVENT_IRQ && i_pstrb[2]))
    else $error("interrupt dropped without a clear write");
  a_reset_all_zero: assert property ($fell(i_srst) |-> !(o_clock_irq ||
    o_usb_ctrl_reset || o_port_a_reset || o_random_gen_reset || o_psram_if_reset))
    else $error("output not zero after reset");
  a_usb_bit_write: assert property (wr1 && i_pstrb[3] |=> o_usb_ctrl_reset == $past(i_pwdata[29]))
    else $error("usb reset not written");
  a_port_a_write: assert property (wr1 && i_pstrb[0] |=> o_port_a_reset == $past(i_pwdata[0]))
    else $error("port a reset not written");
  a_port_a_hold: assert property (!(wr1 && i_pstrb[0]) |=> $stable(o_port_a_reset))
    else $error("port a reset changed without a write");
  a_random_bit_write: assert property (wr && i_paddr == CIRQ_OFS_HSBUS2_RESET && i_pstrb[0]
    |=> o_random_gen_reset == $past(i_pwdata[6]))
    else $error("random generator reset not written");
  a_psram_bit_write: assert property (wr && i_paddr == CIRQ_OFS_HSBUS3_RESET && i_pstrb[0]
    |=> o_psram_if_reset == $past(i_pwdata[0]))
    else $error("psram reset not written");
  c_unmapped: cover property (acc && !mapped);
  c_irq_rise: cover property ($rose(o_clock_irq));
  c_irq_fall: cover property ($fell(o_clock_irq));
endmodule : cirq_regs_chk
bind cirq_regs cirq_regs_chk u_cirq_regs_chk (.i_ref_clk, .i_srst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr, .o_clock_irq,
  .o_usb_ctrl_reset, .o_port_a_reset, .o_random_gen_reset, .o_psram_if_reset);
`default_nettype wire

// File: test_cirq_regs.sv
// testbench for the clock event and peripheral reset register bank
// assumes cirq_regs with a short stuck count, driven over apb and through the ready levels and crystal input
`default_nettype none
module test_cirq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cirq_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [6:0]  stable = 7'h00;
  logic        xtal = 1'b0;
  logic        xtal_run = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        last_err;
  logic [31:0] r;
  wire  [31:0] b1;
  wire  [31:0] b2;
  wire  [31:0] b3;
  int          mismatches = 0;
  int          comparisons = 0;
  // ----------------------------------------------------------------
  // design and stimulus sources
  // ----------------------------------------------------------------
  cirq_regs #(.STUCK_CYCLES(4)) u_cirq_regs (.i_ref_clk(clk), .i_srst(srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_src_stable(stable), .i_high_speed_crystal(xtal), .o_clock_irq(irq),
    .o_usb_ctrl_reset(b1[29]), .o_dma_second_reset(b1[22]), .o_dma_first_reset(b1[21]),
    .o_wireless_reset(b1[13]), .o_checksum_reset(b1[12]), .o_touch_sense_reset(b1[8]),
    .o_security_gate_reset(b1[7]), .o_port_c_reset(b1[2]), .o_port_b_reset(b1[1]),
    .o_port_a_reset(b1[0]), .o_random_gen_reset(b2[6]), .o_hash_unit_reset(b2[5]),
    .o_cipher_unit_reset(b2[4]), .o_public_key_unit_reset(b2[3]),
    .o_camera_if_reset(b2[0]), .o_quad_flash_if_reset(b3[1]), .o_psram_if_reset(b3[0]));
  // reserved positions have no output; tie them so whole words compare cleanly
  assign b1[31:30] = 2'h0;
  assign b1[28:23] = 6'h00;
  assign b1[20:14] = 7'h00;
  assign b1[11:9]  = 3'h0;
  assign b1[6:3]   = 4'h0;
  assign b2[31:7]  = 25'h000_0000;
  assign b2[2:1]   = 2'h0;
  assign b3[31:2]  = 30'h0000_0000;
  initial forever #5 clk = ~clk;
  // a toggling crystal keeps the stuck monitor quiet until a scenario halts it
  always @(posedge clk) if (xtal_run) xtal <= ~xtal;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one transfer; an idle edge follows so the next setup never collides with the release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      check("pready", 32'h1, 32'h0);
      tally_and_finish();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(nm, exp, r);
  endtask : rdchk
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk("event reg reset", 8'h0C, 32'h0000_0000);
    rdchk("bus1 reset", 8'h10, 32'h0000_0000);
    rdchk("bus2 reset", 8'h14, 32'h0000_0000);
    rdchk("bus3 reset", 8'h18, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h2060_3187, 4'hF);
    rdchk("bus1 bits", 8'h10, 32'h2060_3187);
    check("bus1 outputs", 32'h2060_3187, b1 & 32'h2060_3187);
    apb(1'b1, 8'h14, 32'h0000_0079, 4'h3);
    apb(1'b1, 8'h14, 32'h0000_0000, 4'hE);
    rdchk("bus2 lanes kept", 8'h14, 32'h0000_0079);
    check("bus2 outputs", 32'h0000_0079, b2 & 32'h0000_0079);
    apb(1'b1, 8'h14, 32'h0000_0000, 4'h1);
    rdchk("bus2 byte clear", 8'h14, 32'h0000_0000);
    apb(1'b1, 8'h18, 32'h0000_0003, 4'hF);
    check("bus3 outputs", 32'h0000_0003, b3 & 32'h0000_0003);
    apb(1'b1, 8'h10, 32'h0000_0000, 4'hF);
    check("bus1 released", 32'h0000_0000, b1 & 32'h2060_3187);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    check("unmapped write error", 32'h1, {31'h0, last_err});
    rdchk("unmapped read", 8'h40, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_7FFF, 4'h3);
    rdchk("enables, flags read-only", 8'h0C, 32'h0000_7F00);
    for (int n = 0; n < 7; n++)
    begin
      stable <= stable | (7'h01 << n);
      repeat (3) @(posedge clk);
      rdchk("flag set", 8'h0C, 32'h0000_7F00 | (32'h1 << n));
      check("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, 8'h0C, 32'h1 << (16 + n), 4'h4);
      rdchk("flag cleared", 8'h0C, 32'h0000_7F00);
      check("irq off", 32'h0, {31'h0, irq});
    end
    apb(1'b1, 8'h0C, 32'h0000_0000, 4'h2);
    stable <= 7'h00;
    repeat (2) @(posedge clk);
    stable <= 7'h7F;
    repeat (3) @(posedge clk);
    rdchk("disabled sources", 8'h0C, 32'h0000_0000);
    xtal_run <= 1'b0;
    repeat (10) @(posedge clk);
    rdchk("stuck, monitor off", 8'h0C, 32'h0000_0000);
    apb(1'b1, CIRQ_OFS_MONITOR_CTRL, 32'h0000_0001, 4'h1);
    repeat (8) @(posedge clk);
    rdchk("stuck flag", 8'h0C, 32'h0000_0080);
    check("irq stuck", 32'h1, {31'h0, irq});
    xtal_run <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b1, 8'h0C, 32'h0080_0000, 4'h4);
    rdchk("stuck cleared", 8'h0C, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : test_cirq_regs
`default_nettype wire
